// >>> logic/asq_pkg.sv
// Shared constants and carrier types for the converter scan sequencer
package asq_pkg;
  localparam int NUM_CH = 16;
  localparam int NUM_CFG = 4;
  localparam int CODE_W = 12;
  localparam int RES_W = 16;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CFG = 12'h010;
  localparam logic [11:0] OFS_RESULT = 12'h040;
  localparam logic [11:0] OFS_CHCFG = 12'h100;
  localparam logic [11:0] OFS_CHCFG_END = 12'h200;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXTCLK = 1;
  localparam int CTRL_CFG_LSB = 2;
  localparam int CTRL_SIGN_SE = 4;
  localparam int CTRL_SIGN_DIFF = 5;
  localparam int CTRL_DIV_LSB = 8;
  // Scan configuration fields
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_TRIG = 16;
  localparam int CFG_PER_LSB = 20;
  // Channel configuration fields
  localparam int CH_ACQ_LSB = 0;
  localparam int CH_RES_LSB = 8;
  localparam int CH_AVG_LSB = 10;
  localparam int CH_LOG_LSB = 12;
  localparam int CH_DIFF = 15;
  localparam logic [2:0] AVG_LOG_MAX = 3'h4;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] AVG_NONE = 2'h0;
  localparam logic [1:0] AVG_SEQ = 2'h1;
  localparam logic [1:0] AVG_INTER = 2'h2;
  // Conversion overhead of 2.5 periods, held in half periods
  localparam int CONV_EXTRA_HALF = 5;
  // Aggregate rate limit: one sample per microsecond
  localparam int CLK_NS = 40;
  localparam int MIN_SAMPLE_NS = 1000;
  localparam int MIN_SAMPLE_CYC = (MIN_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] SDONE_TICKS = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACQ, S_CONV} asq_seq_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } asq_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asq_axi_rsp_t;

  typedef struct packed {
    logic [3:0] muxSel;
    logic negCommon;
    logic diffMode;
    logic sampling;
    logic converting;
  } asq_conv_t;
endpackage

// >>> logic/asq_scan_seq.sv
// Scan sequencer for a successive-approximation converter with AXI4-Lite registers
// How it works
// - Scan up to sixteen channels, own result each
// - Resolution selectable as 8, 10 or 12 bits
// - Averaging accumulates results up to sixteen bits
// - Four configurations, switchable while running
// - Aggregate rate at most one million samples/second
// - Averaging set per channel independently
// - Sample-done high exactly two converter clocks
// - Sample-done advances the input multiplexer
// - Scan-complete rises when scan finished
// - Non-interleaved enabled channels valid at scan-complete
// - Interleaved result valid after count scans
// - Sequential averaging samples channel repeatedly per scan
// - Other channels sampled once per scan
// - Sample is acquisition plus bits+2.5 clocks
// - Trigger input used only by triggered configurations
// - Continuous mode repeats scans at configured rate
// - Converter clock external when enabled, else divided
// - Single-ended channels use common negative source
// - Results right-justified, sign chosen per input type
// - Signed twelve-bit spans 0xF800 to 0x07FF
`timescale 1ns/1ps
module asq_scan_seq #(
  parameter int NUM_CH = asq_pkg::NUM_CH,
  parameter int NUM_CFG = asq_pkg::NUM_CFG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire asq_pkg::asq_axi_req_t axiReq,
  output asq_pkg::asq_axi_rsp_t axiRsp,
  // Converter clock and trigger
  input wire logic aclk,
  input wire logic soc,
  // Converter core
  input wire logic [asq_pkg::CODE_W-1:0] adcCode,
  output asq_pkg::asq_conv_t conv,
  // Events
  output logic sdone,
  output logic eos
);
  localparam int CI_W = $clog2(NUM_CFG * NUM_CH);

  typedef struct packed {
    asq_pkg::asq_axi_rsp_t rsp;
    logic [11:0] awAddr;
    logic awHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHave;
    logic [31:0] ctrl;
    logic [NUM_CFG-1:0][31:0] cfg;
    logic [NUM_CFG*NUM_CH-1:0][15:0] chCfg;
    logic [NUM_CH-1:0][15:0] result;
    logic [NUM_CH-1:0] valid;
    logic [NUM_CH-1:0][15:0] acc;
    logic [NUM_CH-1:0][4:0] accCnt;
    asq_pkg::asq_seq_t seq;
    logic [3:0] ch;
    logic [1:0] actCfg;
    logic [7:0] phaseCnt;
    logic [7:0] divCnt;
    logic tick;
    logic [2:0] aclkS;
    logic [2:0] socS;
    logic [11:0] periodCnt;
    logic [7:0] rateCnt;
    logic [1:0] sdoneCnt;
    logic sdone;
    logic eos;
    logic [7:0] scanCount;
    asq_pkg::asq_conv_t conv;
  } asq_state_t;

  asq_state_t st;
  asq_state_t next_st;

  function automatic logic [4:0] resBits(input logic [1:0] r);
    if (r == asq_pkg::RES_8) return 5'd8;
    if (r == asq_pkg::RES_10) return 5'd10;
    return 5'd12;
  endfunction

  // Right-justified, optionally signed about mid-scale
  function automatic logic [15:0] fmtCode(input logic [11:0] code, input logic [1:0] r,
                                          input logic sgn);
    logic [15:0] u;
    logic [4:0] b;
    b = resBits(r);
    u = {4'h0, code} & ((16'h0001 << b) - 16'h0001);
    if (sgn) u = u - (16'h0001 << (b - 5'd1));
    return u;
  endfunction

  // Lowest enabled channel at or above a start index
  function automatic logic [4:0] firstCh(input logic [15:0] mask, input logic [4:0] from);
    logic [4:0] res;
    res = 5'h10;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && 5'(i) >= from) res = 5'(i);
    end
    return res;
  endfunction

  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic inRange(input logic [11:0] a, input logic [11:0] lo,
                                   input logic [11:0] hi);
    return a >= lo && a < hi;
  endfunction

  always_comb begin
    logic [11:0] a;
    logic [CI_W-1:0] ix;
    logic [31:0] cc;
    logic [15:0] chw;
    logic [15:0] sum;
    logic [4:0] cntN;
    logic [4:0] nxt;
    logic [2:0] lg;
    logic done;
    logic start;
    logic socRise;
    next_st = st;
    a = 12'h000;
    ix = '0;
    cc = st.cfg[st.actCfg];
    chw = st.chCfg[{st.actCfg, st.ch}];
    sum = 16'h0000;
    cntN = 5'h00;
    nxt = 5'h00;
    lg = 3'h0;
    done = 1'b0;
    start = 1'b0;
    socRise = st.socS[1] && !st.socS[2];

    // Write channel: address and data in either order
    if (axiReq.awvalid && st.rsp.awready) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st.rsp.wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
    end
    if (st.rsp.bvalid && axiReq.bready) next_st.rsp.bvalid = 1'b0;
    if (next_st.awHave && next_st.wHave && !st.rsp.bvalid) begin
      a = {next_st.awAddr[11:2], 2'b00};
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = asq_pkg::RESP_OKAY;
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      if (a == asq_pkg::OFS_CTRL) begin
        next_st.ctrl = wrMerge(st.ctrl, next_st.wData, next_st.wStrb);
      end else if (inRange(a, asq_pkg::OFS_CFG, asq_pkg::OFS_CFG + 12'(4 * NUM_CFG))) begin
        ix = CI_W'((a - asq_pkg::OFS_CFG) >> 2);
        next_st.cfg[ix[1:0]] = wrMerge(st.cfg[ix[1:0]], next_st.wData, next_st.wStrb);
      end else if (inRange(a, asq_pkg::OFS_CHCFG, asq_pkg::OFS_CHCFG_END)) begin
        ix = CI_W'((a - asq_pkg::OFS_CHCFG) >> 2);
        next_st.chCfg[ix] = 16'(wrMerge({16'h0000, st.chCfg[ix]}, next_st.wData,
                                        next_st.wStrb));
      end else if (a != asq_pkg::OFS_STATUS &&
                   !inRange(a, asq_pkg::OFS_RESULT, asq_pkg::OFS_RESULT + 12'(4 * NUM_CH))) begin
        next_st.rsp.bresp = asq_pkg::RESP_SLVERR;
      end
    end
    next_st.rsp.awready = !next_st.awHave && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.wHave && !next_st.rsp.bvalid;

    // Read channel: answer one cycle after the address is taken
    if (st.rsp.rvalid && axiReq.rready) begin
      next_st.rsp.rvalid = 1'b0;
      next_st.rsp.arready = 1'b1;
    end
    if (axiReq.arvalid && st.rsp.arready) begin
      a = {axiReq.araddr[11:2], 2'b00};
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp = asq_pkg::RESP_OKAY;
      next_st.rsp.rdata = 32'h0000_0000;
      if (a == asq_pkg::OFS_CTRL) begin
        next_st.rsp.rdata = st.ctrl;
      end else if (a == asq_pkg::OFS_STATUS) begin
        next_st.rsp.rdata = {st.valid, st.scanCount, st.ch, 1'b0, st.actCfg,
                             st.seq != asq_pkg::S_IDLE};
      end else if (inRange(a, asq_pkg::OFS_CFG, asq_pkg::OFS_CFG + 12'(4 * NUM_CFG))) begin
        ix = CI_W'((a - asq_pkg::OFS_CFG) >> 2);
        next_st.rsp.rdata = st.cfg[ix[1:0]];
      end else if (inRange(a, asq_pkg::OFS_RESULT, asq_pkg::OFS_RESULT + 12'(4 * NUM_CH))) begin
        ix = CI_W'((a - asq_pkg::OFS_RESULT) >> 2);
        next_st.rsp.rdata = {16'h0000, st.result[ix[3:0]]};
      end else if (inRange(a, asq_pkg::OFS_CHCFG, asq_pkg::OFS_CHCFG_END)) begin
        ix = CI_W'((a - asq_pkg::OFS_CHCFG) >> 2);
        next_st.rsp.rdata = {16'h0000, st.chCfg[ix]};
      end else begin
        next_st.rsp.rresp = asq_pkg::RESP_SLVERR;
      end
    end

    // Converter clock tick: external edge or internal divider
    next_st.aclkS = {st.aclkS[1:0], aclk};
    next_st.socS = {st.socS[1:0], soc};
    next_st.tick = 1'b0;
    if (st.ctrl[asq_pkg::CTRL_EXTCLK]) begin
      next_st.tick = st.aclkS[1] && !st.aclkS[2];
      next_st.divCnt = 8'h00;
    end else if (st.divCnt >= st.ctrl[asq_pkg::CTRL_DIV_LSB +: 8]) begin
      next_st.tick = 1'b1;
      next_st.divCnt = 8'h00;
    end else begin
      next_st.divCnt = st.divCnt + 8'h01;
    end

    if (st.rateCnt != 8'h00) next_st.rateCnt = st.rateCnt - 8'h01;
    next_st.eos = 1'b0;
    if (st.tick && st.sdone) begin
      next_st.sdoneCnt = st.sdoneCnt - 2'h1;
      if (st.sdoneCnt == 2'h1) next_st.sdone = 1'b0;
    end
    if (st.tick && st.periodCnt != 12'h000) next_st.periodCnt = st.periodCnt - 12'h001;

    if (!st.ctrl[asq_pkg::CTRL_RUN]) begin
      // Results and valid flags stay; only in-flight work is dropped
      next_st.seq = asq_pkg::S_IDLE;
      next_st.acc = '0;
      next_st.accCnt = '0;
      next_st.periodCnt = 12'h000;
      next_st.conv.sampling = 1'b0;
      next_st.conv.converting = 1'b0;
    end else begin
      unique case (st.seq)
        asq_pkg::S_IDLE: begin
          next_st.actCfg = st.ctrl[asq_pkg::CTRL_CFG_LSB +: 2];
          cc = st.cfg[next_st.actCfg];
          if (cc[asq_pkg::CFG_TRIG]) start = socRise;
          else start = st.periodCnt == 12'h000;
          nxt = firstCh(cc[asq_pkg::CFG_MASK_LSB +: 16], 5'h00);
          if (start && !nxt[4]) begin
            next_st.ch = nxt[3:0];
            next_st.seq = asq_pkg::S_WAIT;
            next_st.periodCnt = cc[asq_pkg::CFG_PER_LSB +: 12];
          end
        end
        asq_pkg::S_WAIT: begin
          if (st.rateCnt == 8'h00) begin
            next_st.seq = asq_pkg::S_ACQ;
            next_st.rateCnt = 8'(asq_pkg::MIN_SAMPLE_CYC - 1);
            next_st.phaseCnt = chw[asq_pkg::CH_ACQ_LSB +: 8];
            next_st.conv.sampling = 1'b1;
          end
        end
        asq_pkg::S_ACQ: begin
          if (st.tick) begin
            if (st.phaseCnt == 8'h00) begin
              // Bits + 2.5 periods, rounded up to whole ticks
              next_st.phaseCnt = 8'((2 * resBits(chw[asq_pkg::CH_RES_LSB +: 2])
                                     + asq_pkg::CONV_EXTRA_HALF + 1) / 2 - 1);
              next_st.seq = asq_pkg::S_CONV;
              next_st.conv.sampling = 1'b0;
              next_st.conv.converting = 1'b1;
            end else begin
              next_st.phaseCnt = st.phaseCnt - 8'h01;
            end
          end
        end
        asq_pkg::S_CONV: begin
          if (st.tick) begin
            if (st.phaseCnt == 8'h00) begin
              next_st.conv.converting = 1'b0;
              sum = st.acc[st.ch] + fmtCode(adcCode, chw[asq_pkg::CH_RES_LSB +: 2],
                    chw[asq_pkg::CH_DIFF] ? st.ctrl[asq_pkg::CTRL_SIGN_DIFF]
                                          : st.ctrl[asq_pkg::CTRL_SIGN_SE]);
              lg = chw[asq_pkg::CH_LOG_LSB +: 3];
              if (lg > asq_pkg::AVG_LOG_MAX) lg = asq_pkg::AVG_LOG_MAX;
              if (chw[asq_pkg::CH_AVG_LSB +: 2] == asq_pkg::AVG_NONE) lg = 3'h0;
              cntN = st.accCnt[st.ch] + 5'h01;
              done = cntN == (5'h01 << lg);
              if (done) begin
                next_st.result[st.ch] = sum;
                next_st.valid[st.ch] = 1'b1;
                next_st.acc[st.ch] = 16'h0000;
                next_st.accCnt[st.ch] = 5'h00;
              end else begin
                next_st.acc[st.ch] = sum;
                next_st.accCnt[st.ch] = cntN;
              end
              next_st.sdone = 1'b1;
              next_st.sdoneCnt = asq_pkg::SDONE_TICKS;
              nxt = firstCh(cc[asq_pkg::CFG_MASK_LSB +: 16], {1'b0, st.ch} + 5'h01);
              if (chw[asq_pkg::CH_AVG_LSB +: 2] == asq_pkg::AVG_SEQ && !done) begin
                next_st.seq = asq_pkg::S_WAIT;
              end else if (!nxt[4]) begin
                next_st.ch = nxt[3:0];
                next_st.seq = asq_pkg::S_WAIT;
              end else begin
                next_st.eos = 1'b1;
                next_st.scanCount = st.scanCount + 8'h01;
                next_st.seq = asq_pkg::S_IDLE;
              end
            end else begin
              next_st.phaseCnt = st.phaseCnt - 8'h01;
            end
          end
        end
      endcase
    end
    next_st.conv.muxSel = next_st.ch;
    next_st.conv.diffMode = next_st.chCfg[{next_st.actCfg, next_st.ch}][asq_pkg::CH_DIFF];
    next_st.conv.negCommon = !next_st.conv.diffMode;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.rsp.awready <= 1'b1;
      st.rsp.wready <= 1'b1;
      st.rsp.arready <= 1'b1;
      st.ctrl <= asq_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign axiRsp = st.rsp;
  assign conv = st.conv;
  assign sdone = st.sdone;
  assign eos = st.eos;

  logic [2:0] sdTicks;
  logic [7:0] sinceAcq;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdTicks <= 3'h0;
      sinceAcq <= 8'hff;
    end else begin
      if (!st.sdone && next_st.sdone) sdTicks <= 3'h0;
      else if (st.sdone && st.tick && sdTicks != 3'h7) sdTicks <= sdTicks + 3'h1;
      if (st.seq != asq_pkg::S_ACQ && next_st.seq == asq_pkg::S_ACQ) sinceAcq <= 8'h00;
      else if (sinceAcq != 8'hff) sinceAcq <= sinceAcq + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_convEnd;
    st.seq == asq_pkg::S_CONV && st.tick && st.phaseCnt == 8'h00 && st.ctrl[asq_pkg::CTRL_RUN];
  endsequence
  property p_sdone_len;
    $fell(sdone) |-> sdTicks == 3'h2;
  endproperty
  a_sdone_len: assert property (p_sdone_len) else $error("sample-done length");
  property p_mux_follow;
    s_convEnd |=> sdone && (eos || conv.muxSel > $past(st.ch)
      || $past(st.chCfg[{st.actCfg, st.ch}][asq_pkg::CH_AVG_LSB +: 2]) == asq_pkg::AVG_SEQ);
  endproperty
  a_mux_follow: assert property (p_mux_follow) else $error("mux not advanced");
  property p_rate;
    $rose(conv.sampling) |-> $past(sinceAcq) >= 8'(asq_pkg::MIN_SAMPLE_CYC - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("samples too close");
  property p_eos_idle;
    $rose(eos) |-> st.seq == asq_pkg::S_IDLE ##1 !eos;
  endproperty
  a_eos_idle: assert property (p_eos_idle) else $error("scan end misplaced");
  property p_stop;
    !st.ctrl[asq_pkg::CTRL_RUN] |=> st.seq == asq_pkg::S_IDLE && $stable(st.result);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_trig_ignored;
    st.seq == asq_pkg::S_IDLE && next_st.seq == asq_pkg::S_IDLE && st.ctrl[asq_pkg::CTRL_RUN]
      && st.cfg[next_st.actCfg][asq_pkg::CFG_TRIG]
      && st.cfg[next_st.actCfg][asq_pkg::CFG_MASK_LSB +: 16] != '0 |-> !st.socS[1] || st.socS[2];
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger lost");
  property p_bhold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_neg;
    conv.sampling |-> conv.negCommon != st.chCfg[{st.actCfg, st.ch}][asq_pkg::CH_DIFF];
  endproperty
  a_neg: assert property (p_neg) else $error("negative input wrong");
endmodule // asq_scan_seq

// >>> tb/asq_front_model.sv
// Converter core and analog front-end model for the scan sequencer
`timescale 1ns/1ps
module asq_front_model (
  // Clock
  input wire logic clk,
  // Sequencer side and bench input level
  input wire asq_pkg::asq_conv_t conv,
  input wire logic [11:0] base,
  // Core result
  output logic [11:0] adcCode
);
  initial adcCode = 12'h000;
  always @(posedge clk) begin
    if (conv.converting) begin
      adcCode <= base + {8'h00, conv.muxSel};
    end else begin
      // Result inverted every clock outside conversion
      adcCode <= ~adcCode;
    end
  end
endmodule // asq_front_model

// >>> tb/asq_scan_seq_tb_top.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
module asq_scan_seq_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic aclk = 1'b0;
  logic soc = 1'b0;
  logic sdone;
  logic eos;
  logic [11:0] adcCode;
  logic [11:0] base = 12'h000;
  asq_pkg::asq_axi_req_t req = '0;
  asq_pkg::asq_axi_rsp_t rsp;
  asq_pkg::asq_conv_t conv;
  int miscompares = 0;
  int checked = 0;
  int sdoneLen = 2;
  int pulseLen = 0;
  int pulses = 0;
  int eosCnt = 0;
  logic prevSamp = 1'b0;
  logic chDiff = 1'b0;
  logic [1:0] aclkDiv = 2'h0;
  logic [15:0] diffTab = 16'h0000;
  logic [33:0] e;
  logic [33:0] m;
  logic [33:0] expQ[$];
  logic [33:0] mskQ[$];
  localparam logic [33:0] ALL = 34'h3_ffff_ffff;

  always #20 clk = ~clk;
  // Free-running converter clock, six bench clocks per period
  always @(posedge clk) begin
    aclkDiv <= (aclkDiv == 2'h2) ? 2'h0 : aclkDiv + 2'h1;
    if (aclkDiv == 2'h2) aclk <= ~aclk;
  end

  asq_scan_seq dut (.clk(clk), .rst_b(rst_b), .axiReq(req), .axiRsp(rsp), .aclk(aclk),
    .soc(soc), .adcCode(adcCode), .conv(conv), .sdone(sdone), .eos(eos));
  asq_front_model front (.clk(clk), .conv(conv), .base(base), .adcCode(adcCode));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic fail();
    miscompares++;
    $display("CHECK FAILED at %0t: wait limit reached", $time);
    results();
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    mskQ.push_back({2'h3, 32'h0});
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        return;
      end
    end
    fail();
  endtask

  task automatic axr(input logic [11:0] a, input logic [33:0] x, input logic [33:0] k);
    expQ.push_back(x);
    mskQ.push_back(k);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        return;
      end
    end
    fail();
  endtask

  task automatic waitEos(input int target);
    for (int n = 0; n < 5000; n++) begin
      @(posedge clk);
      if (eosCnt >= target) return;
    end
    fail();
  endtask

  // Response and event watcher
  always @(posedge clk) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      check((rsp.bvalid ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata}) & m, e & m);
    end
    if (sdone === 1'b1) begin
      pulseLen++;
    end else if (pulseLen != 0) begin
      check(34'(pulseLen), 34'(sdoneLen));
      pulses++;
      pulseLen = 0;
    end
    if (eos === 1'b1) eosCnt++;
    if (conv.sampling === 1'b1 && !prevSamp) begin
      chDiff = diffTab[conv.muxSel];
      check({32'h0, conv.diffMode, conv.negCommon}, {32'h0, chDiff, ~chDiff});
    end
    prevSamp = conv.sampling;
  end

  initial begin
    void'($urandom(10));
    base <= 12'($urandom % 224);
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    axr(asq_pkg::OFS_CTRL, 34'h0, ALL);
    axr(12'h008, {asq_pkg::RESP_SLVERR, 32'h0}, ALL);
    axw(12'h020, 32'h1, asq_pkg::RESP_SLVERR);
    $display("Test registers: done");
    // Triggered scan of channels 0, 3 and 15, divided clock
    diffTab = 16'h8000;
    sdoneLen = 4;
    axw(12'h010, 32'h0001_8009, asq_pkg::RESP_OKAY);
    axw(12'h100, 32'h0000_0202, asq_pkg::RESP_OKAY);
    axw(12'h10c, 32'h0000_2402, asq_pkg::RESP_OKAY);
    axw(12'h13c, 32'h0000_8102, asq_pkg::RESP_OKAY);
    axw(asq_pkg::OFS_CTRL, 32'h0000_0121, asq_pkg::RESP_OKAY);
    repeat (250) @(posedge clk);
    soc <= 1'b1;
    repeat (4) @(posedge clk);
    soc <= 1'b0;
    waitEos(1);
    axr(12'h040, {22'h0, base}, ALL);
    axr(12'h04c, {22'h0, 12'((base + 12'h3) * 4)}, ALL);
    axr(12'h07c, {18'h0, 16'({4'h0, base} + 16'hf - 16'h200)}, ALL);
    axr(asq_pkg::OFS_STATUS, 34'h0_8009_0000, 34'h3_ffff_0001);
    check(34'(pulses), 34'd6);
    $display("Test triggered scan: done");
    // Continuous interleaved scan on configuration 1, external clock
    diffTab = 16'h0000;
    sdoneLen = 12;
    axw(12'h014, 32'h0000_0004, asq_pkg::RESP_OKAY);
    axw(12'h148, 32'h0000_1a02, asq_pkg::RESP_OKAY);
    axw(asq_pkg::OFS_CTRL, 32'h0000_0007, asq_pkg::RESP_OKAY);
    waitEos(2);
    // Interleaved channel still not valid after its first scan
    axr(asq_pkg::OFS_STATUS, 34'h0, 34'h3_0004_0000);
    waitEos(3);
    axw(asq_pkg::OFS_CTRL, 32'h0000_0006, asq_pkg::RESP_OKAY);
    axr(12'h048, {22'h0, 12'((base + 12'h2) * 2)}, ALL);
    axr(12'h040, {22'h0, base}, ALL);
    // Let the last sample-done pulse and read check finish
    repeat (16) @(posedge clk);
    check(34'(pulses), 34'd8);
    $display("Test continuous scan: done");
    results();
  end
endmodule // asq_scan_seq_tb_top
